//--- rtl/standstill_pkg.sv
// constants, register map and carrier types for the standstill/stop sequencer
// assumes a 250 MHz pclk and signed speed values in units of 0.01 %
// What this block does
// - speed idle when feedback magnitude below band
// - setpoint idle when its selected source below band
// - half percent hysteresis before idle flags clear
// - halted only when both idle flags set
// - halted plus quench enable quenches loops, contactor kept
// - quench holds until halted condition drops
// - inverted halted indication to enable logic
// - idle band zero to hundred percent, relay
// - target reached when ramp difference below band
// - run removal ramps demand down by duration
// - non-regen no faster than coast rate
// - stop completion drops contactor, disables drive
// - stop watchdog trips contactor and drive off
// - contactor held for hold interval after zero
// - early disable if level over quarter, fade set
// - enable low cancels the hold interval
// - pass current cap, drive coast/enable signals
// - setpoint idle source selectable, default speed loop demand
// - ramp-down duration 0.1 s to 600 s
// - current fade slope up to 200 %/s
package standstill_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_PERIOD_US = 1000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam int DSEC_US = 100000;
    localparam int TICKS_PER_DSEC = DSEC_US / TICK_PERIOD_US;
    // value limits, 0.01 % and 0.1 s units
    localparam logic [15:0] FULL_SCALE = 16'h2710;
    localparam logic [15:0] IDLE_HYST = 16'h0032;
    localparam logic [15:0] EARLY_OFF_LEVEL = 16'h0019;
    localparam logic [15:0] MAX_200PCT = 16'h4E20;
    localparam logic [15:0] TIME_MAX = 16'h1770;
    localparam logic [15:0] TIME_MIN = 16'h0001;
    localparam logic [15:0] ZERO16 = 16'h0000;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IDLE = 8'h04;
    localparam logic [7:0] OFS_TARGET = 8'h08;
    localparam logic [7:0] OFS_RAMP = 8'h0C;
    localparam logic [7:0] OFS_LIMIT = 8'h10;
    localparam logic [7:0] OFS_HOLD = 8'h14;
    localparam logic [7:0] OFS_FADE = 8'h18;
    localparam logic [7:0] OFS_HALT = 8'h1C;
    localparam logic [7:0] OFS_CAP = 8'h20;
    localparam logic [7:0] OFS_COAST = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    localparam logic [7:0] OFS_DEMAND = 8'h2C;
    // control bit positions
    localparam int CTRL_QUENCH = 0;
    localparam int CTRL_REGEN = 1;
    localparam int CTRL_SRC = 2;
    // reset values
    localparam logic [2:0] RST_CTRL = 3'h0;
    localparam logic [15:0] RST_IDLE = 16'h00C8;
    localparam logic [15:0] RST_TARGET = 16'h0064;
    localparam logic [15:0] RST_RAMP = 16'h0064;
    localparam logic [15:0] RST_LIMIT = 16'h0258;
    localparam logic [15:0] RST_HOLD = 16'h000A;
    localparam logic [15:0] RST_FADE = 16'h0000;
    localparam logic [15:0] RST_HALT = 16'h00C8;
    localparam logic [15:0] RST_CAP = 16'h2710;
    localparam logic [15:0] RST_COAST = 16'h0032;
    // stop sequence states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RUN = 2'b01,
        ST_RAMP = 2'b10,
        ST_HOLD = 2'b11
    } stop_state_e;
    // standstill flags
    typedef struct packed {
        logic speed_idle_flag;
        logic setpoint_idle_flag;
        logic motor_halted_flag;
        logic not_halted;
        logic target_reached_flag;
        logic zero_speed_relay;
    } idle_flags_s;
    // drive sequencing outputs
    typedef struct packed {
        logic contactor_on;
        logic drive_enabled;
        logic run_indicator;
        logic loop_quench;
        logic firing_disable;
        logic coast_stop_request;
    } drive_ctrl_s;
endpackage

//--- rtl/drive_standstill_stop_sequencer.sv
// standstill detection and normal stop sequencing with an APB register file
// assumes all inputs synchronous to pclk; speeds signed 0.01 % units
module drive_standstill_stop_sequencer #(
    parameter int TICK_CYCLES = standstill_pkg::TICK_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic signed [15:0] speed_feedback,
    input wire logic signed [15:0] speed_setpoint,
    input wire logic signed [15:0] speed_loop_demand,
    input wire logic signed [15:0] ramp_input,
    input wire logic signed [15:0] profile_result,
    input wire logic run_command_input,
    input wire logic drive_enable_input,
    output logic signed [15:0] speed_demand,
    output logic [15:0] fast_halt_current_cap,
    output logic [15:0] current_fade_slope,
    output standstill_pkg::idle_flags_s idle_flags,
    output standstill_pkg::drive_ctrl_s drive_ctrl
);
    import standstill_pkg::*;

    // a shorter tick would need over one demand count per pclk
    if (TICK_CYCLES * TICKS_PER_DSEC < int'(FULL_SCALE)) begin : g_bad_tick
        $error("TICK_CYCLES too small for the demand ramp");
    end

    ////////////////////////////////////////////////////////////////////////
    // helpers
    ////////////////////////////////////////////////////////////////////////

    // magnitude of a signed speed; the most negative code gives 16'h8000 exactly
    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        logic [16:0] m;
        m = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
        return m[16] ? 16'hFFFF : m[15:0];
    endfunction

    // limit a written value to its programmable range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // idle comparison: sets below level, clears only past level plus margin
    function automatic logic idle_cmp(input logic flag, input logic [15:0] m,
                                      input logic [15:0] level);
        logic [16:0] top;
        top = {1'b0, level} + {1'b0, IDLE_HYST};
        return flag ? ({1'b0, m} <= top) : (m < level);
    endfunction

    // 0.1 s setting converted to control ticks
    function automatic logic [23:0] to_ticks(input logic [15:0] t);
        return 24'(t) * 24'(TICKS_PER_DSEC);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // register file
    ////////////////////////////////////////////////////////////////////////

    // clamped settings
    logic [2:0] ctrl_reg; // quench enable, regen, setpoint source
    logic [15:0] idle_level_reg; // idle band level
    logic [15:0] target_band_level; // target band level
    logic [15:0] ramp_time_reg; // ramp-down duration
    logic [15:0] limit_time_reg; // stop watchdog time
    logic [15:0] hold_time_reg; // coil hold interval
    logic [15:0] fade_reg; // current fade slope
    logic [15:0] halt_level_reg; // halt detect level
    logic [15:0] cap_reg; // fast halt current cap
    logic [15:0] coast_time_reg; // shortest stop a coasting drive allows
    // bus decode
    logic wr_en; // write takes effect this edge
    logic setup_ph; // first cycle of a transfer
    logic mapped; // address decodes to a register
    logic [31:0] rd_word; // read mux
    stop_state_e state_reg; // stop sequence state
    idle_flags_s flags_reg; // standstill flags
    drive_ctrl_s drv_reg; // sequencing outputs
    logic signed [15:0] demand_reg; // speed demand to the speed loop

    // apb phase decode
    assign setup_ph = psel & ~penable;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;

    // address decode, shared by reads and the error answer
    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (paddr)
            OFS_CTRL: rd_word = 32'(ctrl_reg);
            OFS_IDLE: rd_word = 32'(idle_level_reg);
            OFS_TARGET: rd_word = 32'(target_band_level);
            OFS_RAMP: rd_word = 32'(ramp_time_reg);
            OFS_LIMIT: rd_word = 32'(limit_time_reg);
            OFS_HOLD: rd_word = 32'(hold_time_reg);
            OFS_FADE: rd_word = 32'(fade_reg);
            OFS_HALT: rd_word = 32'(halt_level_reg);
            OFS_CAP: rd_word = 32'(cap_reg);
            OFS_COAST: rd_word = 32'(coast_time_reg);
            OFS_STATUS: rd_word = 32'({drv_reg, flags_reg, state_reg});
            OFS_DEMAND: rd_word = 32'(demand_reg);
            default: mapped = 1'b0; // unmapped: error, reads zero
        endcase
    end

    // no wait state: answer prepared in setup, ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= (mapped && !pwrite) ? rd_word : 32'h0000_0000;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // software writes; values clamped to their programmable ranges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RST_CTRL;
            idle_level_reg <= RST_IDLE;
            target_band_level <= RST_TARGET;
            ramp_time_reg <= RST_RAMP;
            limit_time_reg <= RST_LIMIT;
            hold_time_reg <= RST_HOLD;
            fade_reg <= RST_FADE;
            halt_level_reg <= RST_HALT;
            cap_reg <= RST_CAP;
            coast_time_reg <= RST_COAST;
        end else if (wr_en) begin
            unique case (paddr)
                OFS_CTRL: ctrl_reg <= pwdata[2:0];
                OFS_IDLE: idle_level_reg <= clamp16(pwdata[15:0], ZERO16, FULL_SCALE);
                OFS_TARGET: target_band_level <= clamp16(pwdata[15:0], ZERO16, FULL_SCALE);
                OFS_RAMP: ramp_time_reg <= clamp16(pwdata[15:0], TIME_MIN, TIME_MAX);
                OFS_LIMIT: limit_time_reg <= clamp16(pwdata[15:0], ZERO16, TIME_MAX);
                OFS_HOLD: hold_time_reg <= clamp16(pwdata[15:0], TIME_MIN, TIME_MAX);
                OFS_FADE: fade_reg <= clamp16(pwdata[15:0], ZERO16, MAX_200PCT);
                OFS_HALT: halt_level_reg <= clamp16(pwdata[15:0], ZERO16, FULL_SCALE);
                OFS_CAP: cap_reg <= clamp16(pwdata[15:0], ZERO16, MAX_200PCT);
                OFS_COAST: coast_time_reg <= clamp16(pwdata[15:0], TIME_MIN, TIME_MAX);
                default: ; // status, demand and unmapped ignore writes
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control tick
    ////////////////////////////////////////////////////////////////////////

    // tick divider
    logic [31:0] tick_cnt_reg; // divider toward the control tick
    logic tick_reg; // one-cycle tick pulse

    // periodic tick from pclk; stop timers and flag comparisons step on it, the demand ramp does not
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= 32'h0000_0000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
            tick_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // standstill detection
    ////////////////////////////////////////////////////////////////////////

    // comparator inputs
    logic signed [15:0] idle_src; // setpoint idle comparison input
    logic [16:0] ramp_diff; // |ramp input - ramp output|
    logic sp_idle_next;
    logic fb_idle_next;

    // source select: speed loop demand unless software picks the setpoint
    assign idle_src = ctrl_reg[CTRL_SRC] ? speed_setpoint : speed_loop_demand;
    assign fb_idle_next = idle_cmp(flags_reg.speed_idle_flag, mag16(speed_feedback), idle_level_reg);
    assign sp_idle_next = idle_cmp(flags_reg.setpoint_idle_flag, mag16(idle_src), idle_level_reg);

    // wide difference so a full-range swing cannot wrap
    always_comb begin
        logic signed [16:0] d;
        d = 17'(ramp_input) - 17'(profile_result);
        ramp_diff = d[16] ? 17'(-d) : 17'(d);
    end

    // flags refresh on each tick; halted drops at the tick where either idle flag clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= '0;
        end else if (tick_reg) begin
            flags_reg.speed_idle_flag <= fb_idle_next;
            flags_reg.setpoint_idle_flag <= sp_idle_next;
            flags_reg.motor_halted_flag <= fb_idle_next & sp_idle_next;
            flags_reg.not_halted <= ~(fb_idle_next & sp_idle_next);
            flags_reg.zero_speed_relay <= fb_idle_next;
            flags_reg.target_reached_flag <= ramp_diff < {1'b0, target_band_level};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // normal stop sequence
    ////////////////////////////////////////////////////////////////////////

    // one timer: watchdog, then hold
    logic [23:0] timer_reg; // watchdog or hold count in ticks
    logic at_halt_speed; // feedback below halt detect level
    logic early_disable; // drive off already during the hold
    logic limit_hit;
    logic hold_done;

    // halt speed acted on at ticks, early disable every cycle
    assign at_halt_speed = mag16(speed_feedback) < halt_level_reg;
    assign early_disable = (halt_level_reg > EARLY_OFF_LEVEL) && (fade_reg != ZERO16);
    // timers in ticks
    assign limit_hit = timer_reg >= to_ticks(limit_time_reg);
    assign hold_done = timer_reg >= to_ticks(hold_time_reg);

    // sequencer state and timer; timers advance only on ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_OFF;
            timer_reg <= 24'h000000;
        end else begin
            unique case (state_reg)
                ST_OFF: begin
                    // start needs both run and enable
                    if (run_command_input && drive_enable_input) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // removing run starts the stop and the watchdog
                    if (!run_command_input) begin
                        state_reg <= ST_RAMP;
                        timer_reg <= 24'h000000;
                    end
                end
                ST_RAMP: begin
                    if (run_command_input) begin
                        state_reg <= ST_RUN;
                    end else if (tick_reg && at_halt_speed) begin
                        state_reg <= ST_HOLD;
                        timer_reg <= 24'h000000;
                    end else if (tick_reg && limit_hit) begin
                        state_reg <= ST_OFF;
                    end else if (tick_reg) begin
                        timer_reg <= timer_reg + 24'h000001;
                    end
                end
                ST_HOLD: begin
                    // rerun during the hold avoids cycling the contactor
                    if (run_command_input && drive_enable_input) begin
                        state_reg <= ST_RUN;
                    end else if (!drive_enable_input) begin
                        state_reg <= ST_OFF;
                    end else if (tick_reg && hold_done) begin
                        state_reg <= ST_OFF;
                    end else if (tick_reg) begin
                        timer_reg <= timer_reg + 24'h000001;
                    end
                end
            endcase
        end
    end

    // contactor and enable outputs follow the state; loop quench follows the halted flag and enable input
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drv_reg <= '0;
        end else begin
            drv_reg.contactor_on <= state_reg != ST_OFF;
            drv_reg.run_indicator <= state_reg != ST_OFF;
            drv_reg.drive_enabled <= (state_reg == ST_RUN) || (state_reg == ST_RAMP) ||
                                     (state_reg == ST_HOLD && !early_disable);
            // halt quench keeps the contactor in but stops firing
            drv_reg.loop_quench <= (flags_reg.motor_halted_flag && ctrl_reg[CTRL_QUENCH]) ||
                                   !drive_enable_input;
            drv_reg.firing_disable <= (flags_reg.motor_halted_flag && ctrl_reg[CTRL_QUENCH]) ||
                                      state_reg == ST_OFF ||
                                      (state_reg == ST_HOLD && early_disable);
            // one pulse when the watchdog gives up and the drive coasts
            drv_reg.coast_stop_request <= state_reg == ST_RAMP && !run_command_input &&
                                          tick_reg && !at_halt_speed && limit_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // speed demand ramp
    ////////////////////////////////////////////////////////////////////////

    // ramp runs at pclk rate
    logic [15:0] eff_time; // stop duration actually used
    logic [39:0] ramp_span; // pclk cycles for a full-scale ramp
    logic [39:0] ramp_acc_reg; // fractional step accumulator
    logic [39:0] acc_sum;

    // a coasting drive cannot brake faster than the coast rate
    assign eff_time = (!ctrl_reg[CTRL_REGEN] && coast_time_reg > ramp_time_reg) ?
                      coast_time_reg : ramp_time_reg;
    // cycles per full stop
    assign ramp_span = 40'(eff_time) * 40'(TICKS_PER_DSEC) * 40'(TICK_CYCLES);
    // next accumulator
    assign acc_sum = ramp_acc_reg + 40'(FULL_SCALE);

    // slope runs at pclk for one-count resolution; the span is never below
    // full scale, so at most one count is stepped per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            demand_reg <= 16'sh0000;
            ramp_acc_reg <= 40'h00_0000_0000;
        end else if (state_reg == ST_RUN) begin
            demand_reg <= speed_setpoint;
            ramp_acc_reg <= 40'h00_0000_0000;
        end else if (state_reg == ST_RAMP && !run_command_input) begin
            if (acc_sum >= ramp_span) begin
                ramp_acc_reg <= acc_sum - ramp_span;
                if (demand_reg > 16'sh0000) begin
                    demand_reg <= demand_reg - 16'sh0001;
                end else if (demand_reg < 16'sh0000) begin
                    demand_reg <= demand_reg + 16'sh0001;
                end
            end else begin
                ramp_acc_reg <= acc_sum;
            end
        end else if (state_reg != ST_RAMP) begin
            demand_reg <= 16'sh0000; // hold or off: demand zero
            ramp_acc_reg <= 40'h00_0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    ////////////////////////////////////////////////////////////////////////

    // settings handed to the current loop, registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_halt_current_cap <= RST_CAP;
            current_fade_slope <= RST_FADE;
        end else begin
            fast_halt_current_cap <= cap_reg;
            current_fade_slope <= fade_reg;
        end
    end

    // ports from registers
    assign speed_demand = demand_reg;
    assign idle_flags = flags_reg;
    assign drive_ctrl = drv_reg;
endmodule

//--- test/standstill_chk.sv
// checker: port relations of the standstill and stop sequencer
// assumes it is bound into the sequencer and sees only its ports
module standstill_chk
    import standstill_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic run_command_input,
    input wire logic drive_enable_input,
    input wire logic signed [15:0] speed_demand,
    input wire logic [15:0] fast_halt_current_cap,
    input wire standstill_pkg::idle_flags_s idle_flags,
    input wire standstill_pkg::drive_ctrl_s drive_ctrl
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    a_halt_both: assert property (idle_flags.motor_halted_flag |->
        idle_flags.speed_idle_flag && idle_flags.setpoint_idle_flag) else $error("halted without both idle");
    a_not_halt_inv: assert property (idle_flags.not_halted |->
        !idle_flags.motor_halted_flag) else $error("halt indications agree");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready) else $error("apb answer");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_drop_off: assert property ($fell(drive_ctrl.contactor_on) |->
        !drive_ctrl.drive_enabled) else $error("contactor dropped with drive on");
    a_enable_quench: assert property (!drive_enable_input |-> ##[1:2]
        drive_ctrl.loop_quench) else $error("enable low not quenching");
    a_stop_ramps: assert property ((!run_command_input) [*3] ##0 speed_demand >= 0 |=>
        speed_demand <= $past(speed_demand)) else $error("demand rose in stop");
    a_coast_pulse: assert property (drive_ctrl.coast_stop_request |=>
        !drive_ctrl.coast_stop_request) else $error("coast request too long");
    a_cap_stable: assert property ((!(psel && penable && pwrite)) [*3] |->
        $stable(fast_halt_current_cap)) else $error("cap moved without write");
endmodule
bind drive_standstill_stop_sequencer standstill_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .run_command_input(run_command_input), .drive_enable_input(drive_enable_input),
    .speed_demand(speed_demand), .fast_halt_current_cap(fast_halt_current_cap),
    .idle_flags(idle_flags), .drive_ctrl(drive_ctrl));

//--- test/speed_plant.sv
// speed plant model: the shaft follows the demand one cycle late
// assumes the bench stalls it to mimic a load that will not slow down
module speed_plant (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic signed [15:0] demand,
    output logic signed [15:0] feedback
);
    // a stalled shaft keeps its last speed, so the stop watchdog can trip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            feedback <= 16'sh0000;
        end else if (!stall) begin
            feedback <= demand;
        end
    end
endmodule

//--- test/tb.sv
// testbench: registers over apb, standstill flags and normal stop sequencing
// assumes a 100-cycle control tick and the speed plant on the far side
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import standstill_pkg::*;
    localparam int TK = 100;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic signed [15:0] fb, dem, setp = 16'sh0000, ldem = 16'sh0000, rin = 16'sh0000, rout = 16'sh0000;
    logic run = 1'b0, en = 1'b1, stall = 1'b0;
    logic [15:0] cap, fade;
    idle_flags_s fl;
    drive_ctrl_s ct;
    int n_errors = 0, n_checks = 0, k;
    always #2 pclk = ~pclk;
    drive_standstill_stop_sequencer #(.TICK_CYCLES(TK)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .speed_feedback(fb), .speed_setpoint(setp), .speed_loop_demand(ldem),
        .ramp_input(rin), .profile_result(rout), .run_command_input(run), .drive_enable_input(en),
        .speed_demand(dem), .fast_halt_current_cap(cap), .current_fade_slope(fade), .idle_flags(fl),
        .drive_ctrl(ct));
    speed_plant plant (.pclk(pclk), .presetn(presetn), .stall(stall), .demand(dem), .feedback(fb));
    ////////////////////////////////////////////////////////////////////////
    // one apb transfer; the request is held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask
    // counts cycles until the contactor opens
    task automatic wait_drop();
        k = 0;
        while (ct.contactor_on === 1'b1) begin
            @(posedge pclk);
            k++;
        end
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_IDLE, 32'h0);
        `CHK("idle reset", {16'h0000, RST_IDLE}, q)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, OFS_CAP, 32'h00001234);
        cyc(2);
        `CHK("cap out", 16'h1234, cap)
        ldem <= 16'sh1388;
        setp <= 16'sh0064;
        cyc(3 * TK);
        `CHK("loop source", 1'b0, fl.setpoint_idle_flag)
        `CHK("speed idle", 1'b1, fl.speed_idle_flag)
        `CHK("relay", 1'b1, fl.zero_speed_relay)
        done("registers");
        // quench enable, regenerative, setpoint source
        apb(1'b1, OFS_CTRL, 32'h00000007);
        run <= 1'b1;
        cyc(3 * TK);
        `CHK("halted", 1'b1, fl.motor_halted_flag)
        `CHK("quench", 1'b1, ct.loop_quench)
        `CHK("firing off", 1'b1, ct.firing_disable)
        `CHK("contactor", 1'b1, ct.contactor_on)
        `CHK("not halted", 1'b0, fl.not_halted)
        setp <= 16'sh00DC;
        cyc(3 * TK);
        `CHK("hysteresis", 1'b1, fl.setpoint_idle_flag)
        setp <= 16'sh0104;
        cyc(3 * TK);
        `CHK("halt drop", 1'b0, fl.motor_halted_flag)
        `CHK("not halted", 1'b1, fl.not_halted)
        `CHK("unquench", 1'b0, ct.loop_quench)
        done("standstill");
        apb(1'b1, OFS_RAMP, 32'h1);
        apb(1'b1, OFS_HOLD, 32'h1);
        run <= 1'b0;
        cyc(40 * TK);
        `CHK("demand zero", 16'sh0000, dem)
        `CHK("held", 1'b1, ct.contactor_on)
        `CHK("late disable", 1'b1, ct.drive_enabled)
        wait_drop();
        `CHK("hold span", 1'b1, k > 50 * TK)
        `CHK("drive off", 1'b0, ct.drive_enabled)
        apb(1'b1, OFS_FADE, 32'h64);
        run <= 1'b1;
        cyc(10);
        `CHK("fade out", 16'h0064, fade)
        run <= 1'b0;
        cyc(40 * TK);
        `CHK("early disable", 1'b0, ct.drive_enabled)
        en <= 1'b0;
        cyc(4);
        `CHK("enable cancel", 1'b0, ct.contactor_on)
        en <= 1'b1;
        done("stop");
        apb(1'b1, OFS_LIMIT, 32'h1);
        run <= 1'b1;
        cyc(10);
        stall <= 1'b1;
        run <= 1'b0;
        wait_drop();
        `CHK("watchdog", 1'b1, k > 90 * TK && k < 110 * TK)
        `CHK("trip off", 1'b0, ct.drive_enabled)
        rin <= 16'sh01F4;
        rout <= 16'sh01C2;
        cyc(3 * TK);
        `CHK("target in", 1'b1, fl.target_reached_flag)
        rin <= 16'sh02BC;
        cyc(3 * TK);
        `CHK("target out", 1'b0, fl.target_reached_flag)
        done("watchdog");
        test_done();
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        test_done();
    end
endmodule
